// [rtl/elapsed_alarm_counter.sv]
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// Notes on behaviour
// R1: 48-bit counter advances each real-time clock edge
// R2: Width covers roughly 272 years of counting
// R3: Counter wraps from maximum back to zero
// R4: Only the clock unit reset pin clears counter and compare state
// R5: Counter registers read live, write loads, reset zero
// R6: Low register maps counter bits 15..0
// R7: Middle register maps counter bits 31..16
// R8: High register maps counter bits 47..32
// R9: Three writable compare registers, reset zero
// R10: Comparing resumes at second clock edge after write
// R11: Alarm raised when full 48 bits match
// R12: High compare checks counter bits 47..32
// R13: Low compare checks counter bits 15..0
// R14: Middle compare checks counter bits 31..16
// R15: A slice write changes only that slice
// R16: One pending event per match until acknowledged
module elapsed_time_alarm_counter
(
  input wire logic REF_CLK_IN, // System clock, 250 MHz
  input wire logic RST_IN, // Bus reset, high, synchronous
  input wire logic CLOCK_UNIT_RESET_PIN_N_IN, // Counter reset pin, low
  input wire logic RTC_CLK_IN, // 32.768 kHz real-time clock
  input wire logic HSEL_IN, // Slave select
  input wire logic [31:0] HADDR_IN, // Byte address
  input wire logic [1:0] HTRANS_IN, // Transfer type
  input wire logic HWRITE_IN, // Write when high
  input wire logic [2:0] HSIZE_IN, // Transfer size
  input wire logic HREADY_IN, // Bus ready
  input wire logic [31:0] HWDATA_IN, // Write data
  output logic [31:0] HRDATA_OUT, // Read data
  output logic HREADYOUT_OUT, // Slave ready
  output logic HRESP_OUT, // Response, always OKAY
  output logic IRQ_OUT // Alarm interrupt level
);
  import elapsed_alarm_pkg::*;

  // Bus phase and outputs
  bus_phase_t phase_r, phase_nxt; // Captured address phase
  logic [31:0] rdata_r, rdata_nxt; // Read data
  logic ready_r; // Ready flop
  logic resp_r; // Response flop
  logic irq_r, irq_nxt; // Interrupt flop
  // Counter state
  logic [47:0] count_r, count_nxt; // Elapsed counter
  logic [47:0] alarm_r, alarm_nxt; // Compare value
  logic [1:0] arm_r, arm_nxt; // Edges left before comparing
  logic rtc_d_r; // Delayed real-time clock
  // Interrupt state
  logic [15:0] status_r, status_nxt; // Sticky events
  logic [15:0] mask_r, mask_nxt; // Interrupt mask
  // Decoded strobes
  logic tick; // Real-time clock rising edge
  logic addr_take; // Address phase accepted
  logic [47:0] count_inc; // Counter plus one
  logic alarm_evt; // Match event this cycle
  logic rd_status; // Status read accepted
  logic [31:0] wr_idx; // Index of data-phase write
  logic wr_cl, wr_cm, wr_ch, wr_al, wr_am, wr_ah, wr_mk; // Write strobes

  // Address decode helper
  function automatic logic [31:0] to_idx(input logic [31:0] a);
    to_idx = {2'h0, a[31:2]};
  endfunction

  // Strobes from bus and real-time clock
  always_comb
  begin
    tick = RTC_CLK_IN & ~rtc_d_r;
    addr_take = HSEL_IN & HREADY_IN & (HTRANS_IN == HTRANS_NONSEQ);
    wr_idx = to_idx(phase_r.addr);
    wr_cl = phase_r.valid & phase_r.write & (wr_idx == IDX_COUNT_LOW);
    wr_cm = phase_r.valid & phase_r.write & (wr_idx == IDX_COUNT_MID);
    wr_ch = phase_r.valid & phase_r.write & (wr_idx == IDX_COUNT_HIGH);
    wr_al = phase_r.valid & phase_r.write & (wr_idx == IDX_ALARM_LOW);
    wr_am = phase_r.valid & phase_r.write & (wr_idx == IDX_ALARM_MID);
    wr_ah = phase_r.valid & phase_r.write & (wr_idx == IDX_ALARM_HIGH);
    wr_mk = phase_r.valid & phase_r.write & (wr_idx == IDX_IRQ_MASK);
    rd_status = addr_take & ~HWRITE_IN & (to_idx(HADDR_IN) == IDX_IRQ_STATUS);
    count_inc = count_r + 48'h1; // [R3]
  end

  // Counter, compare and arming next values
  always_comb
  begin
    count_nxt = count_r;
    alarm_nxt = alarm_r;
    arm_nxt = arm_r;
    alarm_evt = 1'b0;
    if (tick)
    begin
      // Advance once per real-time edge; 48 bits last about 272 years
      count_nxt = count_inc; // [R1] [R2] [R3]
      if (arm_r > 2'h1)
        arm_nxt = arm_r - 2'h1; // [R10]
      else
      begin
        arm_nxt = 2'h0;
        // Full-width match against the value being entered
        alarm_evt = (alarm_r == count_inc); // [R11] [R12] [R13] [R14]
      end
    end
    // Slice writes load only their own bits and win over the advance
    if (wr_cl | wr_cm | wr_ch)
    begin
      // Drop the advance so no carry leaks into the untouched slices
      count_nxt = count_r; // [R15]
      alarm_evt = 1'b0;
    end
    if (wr_cl)
      count_nxt[15:0] = HWDATA_IN[15:0]; // [R5] [R6] [R15]
    if (wr_cm)
      count_nxt[31:16] = HWDATA_IN[15:0]; // [R7] [R15]
    if (wr_ch)
      count_nxt[47:32] = HWDATA_IN[15:0]; // [R8] [R15]
    if (wr_al)
      alarm_nxt[15:0] = HWDATA_IN[15:0]; // [R9] [R13] [R15]
    if (wr_am)
      alarm_nxt[31:16] = HWDATA_IN[15:0]; // [R14] [R15]
    if (wr_ah)
      alarm_nxt[47:32] = HWDATA_IN[15:0]; // [R12] [R15]
    if (wr_al | wr_am | wr_ah)
    begin
      // Restart the arming delay; no compare until it expires
      arm_nxt = ARM_EDGES; // [R10]
      alarm_evt = 1'b0;
    end
    // Pin reset overrides everything
    if (!CLOCK_UNIT_RESET_PIN_N_IN)
    begin
      count_nxt = COUNT_RESET; // [R4]
      alarm_nxt = ALARM_RESET; // [R4]
      arm_nxt = 2'h0;
      alarm_evt = 1'b0;
    end
  end

  // Counter domain registers, cleared only by the pin
  always_ff @(posedge REF_CLK_IN)
  begin
    count_r <= count_nxt;
    alarm_r <= alarm_nxt;
    arm_r <= arm_nxt;
    rtc_d_r <= RTC_CLK_IN;
  end

  // Interrupt next values
  always_comb
  begin
    status_nxt = status_r;
    mask_nxt = mask_r;
    // Read clears, a same-cycle event still lands
    if (rd_status)
      status_nxt = 16'h0000;
    if (alarm_evt)
      status_nxt[ALARM_BIT] = 1'b1; // [R16]
    status_nxt[15:1] = 15'h0000;
    if (wr_mk)
      mask_nxt = HWDATA_IN[15:0];
    irq_nxt = |(status_nxt & mask_nxt); // [R16]
  end

  // Bus next values and read mux
  always_comb
  begin
    phase_nxt.valid = addr_take;
    phase_nxt.write = HWRITE_IN;
    phase_nxt.addr = HADDR_IN;
    rdata_nxt = 32'h0000_0000;
    if (addr_take & ~HWRITE_IN)
    begin
      // Next values so a write just ahead is seen
      case (to_idx(HADDR_IN))
        IDX_COUNT_LOW: rdata_nxt = {16'h0000, count_nxt[15:0]}; // [R5] [R6]
        IDX_COUNT_MID: rdata_nxt = {16'h0000, count_nxt[31:16]}; // [R7]
        IDX_COUNT_HIGH: rdata_nxt = {16'h0000, count_nxt[47:32]}; // [R8]
        IDX_ALARM_LOW: rdata_nxt = {16'h0000, alarm_nxt[15:0]}; // [R9]
        IDX_ALARM_MID: rdata_nxt = {16'h0000, alarm_nxt[31:16]};
        IDX_ALARM_HIGH: rdata_nxt = {16'h0000, alarm_nxt[47:32]};
        IDX_IRQ_STATUS: rdata_nxt = {16'h0000, status_r};
        IDX_IRQ_MASK: rdata_nxt = {16'h0000, mask_nxt};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Bus and interrupt registers
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      phase_r <= '0;
      rdata_r <= 32'h0000_0000;
      ready_r <= 1'b1;
      resp_r <= 1'b0;
      status_r <= 16'h0000;
      mask_r <= MASK_RESET;
      irq_r <= 1'b0;
    end
    else
    begin
      phase_r <= phase_nxt;
      rdata_r <= rdata_nxt;
      ready_r <= 1'b1;
      resp_r <= 1'b0;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign HRDATA_OUT = rdata_r;
  assign HREADYOUT_OUT = ready_r;
  assign HRESP_OUT = resp_r;
  assign IRQ_OUT = irq_r;

  // Checks
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (RST_IN);

  logic cnt_wr; // Any counter slice write
  logic pin_ok; // Pin released
  assign cnt_wr = wr_cl | wr_cm | wr_ch;
  assign pin_ok = CLOCK_UNIT_RESET_PIN_N_IN;

  // Compare write followed by edges
  sequence s_cmp_write;
    (wr_al | wr_am | wr_ah) && pin_ok;
  endsequence
  sequence s_first_edge;
    tick && arm_r == ARM_EDGES && !(wr_al | wr_am | wr_ah) && pin_ok;
  endsequence
  // A tick that compares once the arming delay has run out
  sequence s_armed_edge;
    tick && arm_r <= 2'h1 && !cnt_wr && !(wr_al | wr_am | wr_ah) && pin_ok;
  endsequence

  // Counting and wrap
  a_count_advance: assert property (tick && !cnt_wr && pin_ok |=> // [R1]
    count_r == $past(count_r) + 48'h1)
    else $error("counter did not advance on edge");
  a_count_wrap: assert property ( // [R3]
    tick && !cnt_wr && pin_ok && (&count_r) |=> count_r == 48'h0)
    else $error("counter did not wrap to zero");
  // Pin reset clears, bus reset leaves the count alone
  a_pin_clear: assert property (!pin_ok |=> count_r == 48'h0 && alarm_r == 48'h0) // [R4]
    else $error("pin reset did not clear counter");
  a_sys_keeps: assert property ( // [R4]
    disable iff (1'b0) RST_IN && pin_ok && !tick |=> $stable(count_r))
    else $error("bus reset disturbed counter");
  // Counter slices land alone; the middle check watches only the low slice, not the high one
  a_low_slice: assert property (wr_cl && pin_ok |=> // [R6]
    count_r[15:0] == $past(HWDATA_IN[15:0]) && $stable(count_r[47:16]))
    else $error("low counter write wrong");
  a_mid_slice: assert property (wr_cm && pin_ok |=> // [R7]
    count_r[31:16] == $past(HWDATA_IN[15:0]) && $stable(count_r[15:0]))
    else $error("middle counter write wrong");
  a_high_slice: assert property (wr_ch && pin_ok |=> // [R8]
    count_r[47:32] == $past(HWDATA_IN[15:0]) && $stable(count_r[31:0]))
    else $error("high counter write wrong");
  a_cmp_slice: assert property (wr_ah && !wr_al && !wr_am && pin_ok |=> // [R15]
    alarm_r[47:32] == $past(HWDATA_IN[15:0]) && $stable(alarm_r[31:0]))
    else $error("compare write wrong");
  // Arming: a compare write loads the delay, the first tick only counts it down
  a_arm_load: assert property (s_cmp_write |=> arm_r == ARM_EDGES) // [R10]
    else $error("compare write did not load the arming delay");
  a_arm_hold: assert property (s_first_edge |-> !alarm_evt) // [R10]
    else $error("compare ran on first edge");
  a_arm_step: assert property (s_first_edge |=> arm_r == 2'h1) // [R10]
    else $error("first edge did not advance the arming delay");
  a_match_flag: assert property ( // [R11]
    s_armed_edge ##0 alarm_r == count_r + 48'h1 |=> status_r[ALARM_BIT])
    else $error("match did not set status");
  // Only a full-width match on a compare tick may raise the event
  a_match_full: assert property ( // [R11]
    alarm_evt |-> s_armed_edge ##0 alarm_r == count_r + 48'h1)
    else $error("event raised without a full match");
  // Interrupt line and pending status
  a_irq_level: assert property (##1 IRQ_OUT == |(status_r & mask_r)) // [R16]
    else $error("interrupt level wrong");
  a_read_clear: assert property (rd_status && !alarm_evt |=> status_r == 16'h0) // [R16]
    else $error("status read did not clear");
  // Pending event holds until a status read takes it away
  a_sticky_hold: assert property ( // [R16]
    status_r[ALARM_BIT] && !rd_status |=> status_r[ALARM_BIT])
    else $error("pending event lost without a read");
  a_irq_event: assert property ( // [R16]
    alarm_evt && mask_r[ALARM_BIT] && !wr_mk |=> IRQ_OUT)
    else $error("unmasked match did not raise the line");
  // Compare slices land alone
  a_cmp_low: assert property ( // [R13]
    wr_al && !wr_am && !wr_ah && pin_ok |=>
    alarm_r[15:0] == $past(HWDATA_IN[15:0]) && $stable(alarm_r[47:16]))
    else $error("low compare write wrong");
  a_cmp_mid: assert property ( // [R14]
    wr_am && !wr_al && !wr_ah && pin_ok |=>
    alarm_r[31:16] == $past(HWDATA_IN[15:0])
    && $stable(alarm_r[47:32]) && $stable(alarm_r[15:0]))
    else $error("middle compare write wrong");
  // Counter reads return the live count of the read edge
  a_read_low: assert property ( // [R5]
    addr_take && !HWRITE_IN && to_idx(HADDR_IN) == IDX_COUNT_LOW
    |=> HRDATA_OUT == {16'h0000, count_r[15:0]})
    else $error("low counter read not live");
  a_read_high: assert property ( // [R8]
    addr_take && !HWRITE_IN && to_idx(HADDR_IN) == IDX_COUNT_HIGH
    |=> HRDATA_OUT == {16'h0000, count_r[47:32]})
    else $error("high counter read not live");
endmodule

// [shared/elapsed_alarm_pkg.sv]
package elapsed_alarm_pkg;
  // Counter and compare width
  localparam int COUNT_W = 48;
  localparam int SLICE_W = 16;
  // Register indexes; byte address is four times the index
  localparam logic [31:0] IDX_COUNT_LOW = 32'h0b0000c4;
  localparam logic [31:0] IDX_COUNT_MID = 32'h0b0000c6;
  localparam logic [31:0] IDX_COUNT_HIGH = 32'h0b0000c8;
  localparam logic [31:0] IDX_ALARM_HIGH = 32'h0b0000ca;
  localparam logic [31:0] IDX_ALARM_LOW = 32'h0b0000cc;
  localparam logic [31:0] IDX_ALARM_MID = 32'h0b0000ce;
  localparam logic [31:0] IDX_IRQ_STATUS = 32'h0b0000e0;
  localparam logic [31:0] IDX_IRQ_MASK = 32'h0b0000e2;
  // Reset values
  localparam logic [47:0] COUNT_RESET = 48'h0000_0000_0000;
  localparam logic [47:0] ALARM_RESET = 48'h0000_0000_0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  // Status bit of the alarm match event
  localparam int ALARM_BIT = 0;
  // Real-time clock edges before comparing resumes after a compare write
  localparam logic [1:0] ARM_EDGES = 2'h2;
  // AHB transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // Captured address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
  } bus_phase_t;
endpackage

// [tb/tb_elapsed_time_alarm_counter.sv]
`timescale 1ns/100ps
module tb_elapsed_time_alarm_counter;
  import elapsed_alarm_pkg::*;
  logic clk = 1'b0; // 250 MHz bus clock
  logic rst = 1'b1; // Bus reset
  logic pin_n = 1'b0; // Counter reset pin, low active
  logic rtc = 1'b0; // Real-time clock
  logic hsel = 1'b0; // Bus select
  logic [31:0] haddr = 32'h0; // Bus address
  logic [1:0] htrans = 2'h0; // Transfer type
  logic hwrite = 1'b0; // Write flag
  logic [31:0] hwdata = 32'h0; // Write data
  logic [31:0] hrdata; // Read data
  logic hready; // Slave ready, also bus ready
  logic hresp; // Response
  logic irq; // Alarm line
  logic [31:0] tmp; // Scratch read value
  int error_cnt = 0; // Mismatches
  int checked = 0; // Comparisons
  logic [31:0] regs [6] = '{IDX_COUNT_LOW, IDX_COUNT_MID, IDX_COUNT_HIGH,
    IDX_ALARM_HIGH, IDX_ALARM_LOW, IDX_ALARM_MID}; // Register indexes
  always #2 clk = ~clk;
  elapsed_time_alarm_counter dut (.REF_CLK_IN(clk), .RST_IN(rst),
    .CLOCK_UNIT_RESET_PIN_N_IN(pin_n), .RTC_CLK_IN(rtc), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HREADY_IN(hready),
    .HWDATA_IN(hwdata), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .IRQ_OUT(irq));
  // Prints the counts and the verdict, then ends the run
  task stop_test;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Compares one value with its expectation
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      error_cnt++;
    end
  endtask
  // Waits for a rising edge with ready sampled high, bounded
  task wait_ready;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        error_cnt++;
        stop_test();
      end
      @(posedge clk);
    end
  endtask
  // One single-word bus transfer; starts just after a rising edge
  task bus(input logic wr, input logic [31:0] idx, input logic [15:0] wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {idx[29:0], 2'b00};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    wait_ready();
    rd = hrdata;
  endtask
  // Write one register
  task wr(input logic [31:0] idx, input logic [15:0] wd);
    bus(1'b1, idx, wd, tmp);
  endtask
  // Read one register and compare
  task rd(input string what, input logic [31:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 16'h0, tmp);
    check(what, tmp, {16'h0, exp});
  endtask
  // Write the three count slices
  task set_count(input logic [47:0] v);
    wr(IDX_COUNT_LOW, v[15:0]);
    wr(IDX_COUNT_MID, v[31:16]);
    wr(IDX_COUNT_HIGH, v[47:32]);
  endtask
  // n real-time clock periods, six bus clocks each
  task tick(input int n);
    repeat (n)
    begin
      rtc <= 1'b1;
      repeat (3) @(posedge clk);
      rtc <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    pin_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) rd("reset value", regs[i], 16'h0);
    wr(32'h0b0000f0, 16'hffff);
    rd("unmapped", 32'h0b0000f0, 16'h0);
    check("response", {31'h0, hresp}, 32'h0);
    $display("Test reset values done");
    for (int i = 0; i < 6; i++) wr(regs[i], 16'(16'h1111 * (i + 1)));
    wr(IDX_COUNT_MID, 16'hbeef);
    for (int i = 0; i < 6; i++)
      rd("slice", regs[i], i == 1 ? 16'hbeef : 16'(16'h1111 * (i + 1)));
    $display("Test read back done");
    set_count(48'h0003_ffff_ffff);
    tick(1);
    rd("carry low", IDX_COUNT_LOW, 16'h0);
    rd("carry mid", IDX_COUNT_MID, 16'h0);
    rd("carry high", IDX_COUNT_HIGH, 16'h0004);
    set_count(48'hffff_ffff_ffff);
    tick(1);
    for (int i = 0; i < 3; i++) rd("wrap", regs[i], 16'h0);
    set_count(48'h0000_0000_ffff);
    fork
      wr(IDX_COUNT_HIGH, 16'h0007);
      begin
        @(posedge clk);
        rtc <= 1'b1;
      end
    join
    rtc <= 1'b0;
    repeat (2) @(posedge clk);
    rd("tick on write high", IDX_COUNT_HIGH, 16'h0007);
    rd("tick on write mid", IDX_COUNT_MID, 16'h0);
    rd("tick on write low", IDX_COUNT_LOW, 16'hffff);
    $display("Test counting done");
    set_count(48'h0000_0000_0010);
    wr(IDX_ALARM_HIGH, 16'h0);
    wr(IDX_ALARM_MID, 16'h0);
    wr(IDX_ALARM_LOW, 16'h0011);
    tick(1);
    rd("armed no match", IDX_IRQ_STATUS, 16'h0);
    wr(IDX_ALARM_LOW, 16'h0013);
    tick(2);
    check("masked line", {31'h0, irq}, 32'h0);
    wr(IDX_IRQ_MASK, 16'h0001);
    repeat (2) @(posedge clk);
    check("line on match", {31'h0, irq}, 32'h1);
    rd("status set", IDX_IRQ_STATUS, 16'h0001);
    repeat (2) @(posedge clk);
    check("line cleared", {31'h0, irq}, 32'h0);
    rd("status cleared", IDX_IRQ_STATUS, 16'h0);
    wr(IDX_ALARM_MID, 16'h0001);
    wr(IDX_ALARM_LOW, 16'h0015);
    tick(2);
    rd("mid differs", IDX_IRQ_STATUS, 16'h0);
    check("no line", {31'h0, irq}, 32'h0);
    wr(IDX_ALARM_MID, 16'h0000);
    wr(IDX_ALARM_LOW, 16'h0017);
    tick(2);
    check("line with mask set", {31'h0, irq}, 32'h1);
    rd("status again", IDX_IRQ_STATUS, 16'h0001);
    $display("Test alarm done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd("kept on bus reset", IDX_COUNT_LOW, 16'h0017);
    rd("compare kept", IDX_ALARM_LOW, 16'h0017);
    pin_n <= 1'b0;
    @(posedge clk);
    pin_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) rd("pin reset", regs[i], 16'h0);
    $display("Test reset pin done");
    stop_test();
  end
endmodule
